// ---- hw/sdwl_host.sv ----
// host end: queues words and shifts them out as framed serial writes
`timescale 1ns/1ps
module sdwl_host #(
    parameter int WORD_BITS = sdwl_pkg::WORD_BITS,
    parameter int DIV = sdwl_pkg::SCLK_DIV
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic WORD_VALID,
    output logic WORD_READY,
    input wire logic [WORD_BITS-1:0] WORD_DATA,
    output logic BUSY,
    sdwl_link_if.host LINK
);
    // a zero divider would leave the link clock unbounded
    if (DIV < 1) begin : g_bad_div
        $error("divider must be at least one");
    end
    typedef enum logic [1:0] {SDWL_IDLE, SDWL_LOW, SDWL_HIGH, SDWL_END} sdwl_state_t;
    sdwl_state_t state;
    logic f_valid;
    logic f_ready;
    logic [WORD_BITS-1:0] f_data;
    logic [WORD_BITS-1:0] shreg;
    logic [$clog2(WORD_BITS+1)-1:0] bits_left;
    logic [$clog2(DIV+1)-1:0] div_cnt;
    logic tick;
    logic sclk;
    logic frame_n;
    logic fifo_ready;
    logic word_take;

    sdwl_fifo #(.WIDTH(WORD_BITS), .DEPTH(sdwl_pkg::FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .rst_n(RSTN),
        .in_valid(word_take),
        .in_ready(fifo_ready),
        .in_data(WORD_DATA),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );
    // only a word offered while the registered ready stands is taken, never a repeat
    assign word_take = WORD_VALID && WORD_READY;
    assign f_ready = (state == SDWL_IDLE);
    assign tick = (div_cnt == '0);
    assign LINK.sclk = sclk;
    assign LINK.frame_n = frame_n;
    assign LINK.sdata = shreg[WORD_BITS-1]; // msb first

    // registered fifo ready, dropped for the cycle after each take, for the user side
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            WORD_READY <= 1'b0;
        end else begin
            WORD_READY <= fifo_ready && !word_take;
        end
    end

    // half-period divider keeps sclk at or below the link limit
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            div_cnt <= '0;
        end else if (state == SDWL_IDLE || tick) begin
            div_cnt <= ($clog2(DIV+1))'(DIV - 1);
        end else begin
            div_cnt <= div_cnt - 1'b1;
        end
    end

    // frame sequencer: data changes on falling sclk, dac samples on rising
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= SDWL_IDLE;
            sclk <= 1'b0;
            frame_n <= 1'b1;
            shreg <= '0;
            bits_left <= '0;
            BUSY <= 1'b0;
        end else begin
            case (state)
                SDWL_IDLE: begin
                    if (f_valid) begin
                        shreg <= f_data;
                        bits_left <= ($clog2(WORD_BITS+1))'(WORD_BITS);
                        frame_n <= 1'b0; // open frame before any edge
                        BUSY <= 1'b1;
                        state <= SDWL_LOW;
                    end
                end
                SDWL_LOW: begin
                    if (tick) begin
                        sclk <= 1'b1; // data stable across this edge
                        bits_left <= bits_left - 1'b1;
                        state <= SDWL_HIGH;
                    end
                end
                SDWL_HIGH: begin
                    if (tick) begin
                        sclk <= 1'b0;
                        if (bits_left == '0) begin
                            state <= SDWL_END;
                        end else begin
                            shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                            state <= SDWL_LOW;
                        end
                    end
                end
                SDWL_END: begin
                    if (tick) begin
                        frame_n <= 1'b1; // close after exactly 14 bits
                        BUSY <= 1'b0;
                        state <= SDWL_IDLE;
                    end
                end
                default: state <= SDWL_IDLE;
            endcase
        end
    end
endmodule

// ---- hw/sdwl_pkg.sv ----
// shared constants for the serial dac word loader
package sdwl_pkg;
    localparam int WORD_BITS = 14;
    localparam int SEG_BITS = 4;
    localparam int SEG_COUNT = 15;
    localparam int LADDER_BITS = 10;
    localparam int FULL_SCALE = 16384;
    localparam logic [13:0] DAC_RESET = 14'h0000;
    localparam int MAX_SCLK_KHZ = 25000;
    localparam int CLK_KHZ = 40000;
    localparam int SCLK_DIV = (CLK_KHZ + 2 * MAX_SCLK_KHZ - 1) / (2 * MAX_SCLK_KHZ);
    localparam int FIFO_DEPTH = 8;
endpackage

// ---- hw/sdwl_link_if.sv ----
// three-wire serial link between host and dac
`timescale 1ns/1ps
interface sdwl_link_if;
    logic sclk;
    logic frame_n;
    logic sdata;
    modport host (output sclk, output frame_n, output sdata);
    modport dac (input sclk, input frame_n, input sdata);
endinterface

// ---- hw/sdwl_fifo.sv ----
// small valid/ready word fifo
`timescale 1ns/1ps
module sdwl_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_wr;
    logic do_rd;
    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    // storage has no reset; only written slots are read
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
        end else if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= '0;
        end else if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ---- hw/sdwl_dac.sv ----
// dac end: serial shift register, dac register and switch decode
`timescale 1ns/1ps
// What this block does
// - power-up output sits at zero code
// - top four bits thermometer to 15 segments
// - low ten bits drive ladder switches directly
// - held word is straight unsigned binary
// - serial clock no faster than 25 MHz
// - bits accepted only while frame low
// - sample data on each rising sclk while frame low
// - fourteen-bit words, msb first
// - frame rise copies shift register to dac
// - dac register zero, shift register undefined
// - extra bits keep last fourteen only
module sdwl_dac #(
    parameter int WORD_BITS = sdwl_pkg::WORD_BITS
) (
    input wire logic CLK,
    input wire logic RSTN,
    sdwl_link_if.dac LINK,
    output logic [sdwl_pkg::SEG_COUNT-1:0] SEGMENT_SWITCH_CTL,
    output logic [sdwl_pkg::LADDER_BITS-1:0] LADDER_SWITCH_CTL,
    output logic [WORD_BITS-1:0] DAC_CODE,
    output logic LOAD_DONE
);
    // segment and ladder fields must tile the word exactly
    if (WORD_BITS != sdwl_pkg::SEG_BITS + sdwl_pkg::LADDER_BITS) begin : g_bad_width
        $error("bad word width");
    end

    // thermometer code: n ones for code n
    function automatic logic [sdwl_pkg::SEG_COUNT-1:0] therm(input logic [3:0] code);
        logic [sdwl_pkg::SEG_COUNT-1:0] t;
        t = '0;
        for (int i = 0; i < sdwl_pkg::SEG_COUNT; i++) begin
            t[i] = (32'(code) > i);
        end
        return t;
    endfunction

    logic [WORD_BITS-1:0] shreg;
    logic [WORD_BITS-1:0] dac_reg;
    logic load_tgl;
    logic [2:0] tgl_sync;

    // input shift register on the link clock; no reset, contents undefined
    always_ff @(posedge LINK.sclk) begin
        if (!LINK.frame_n) begin // idle edges leave it alone
            shreg <= {shreg[WORD_BITS-2:0], LINK.sdata};
        end
    end

    // dac register loads once on each frame rise
    always_ff @(posedge LINK.frame_n or negedge RSTN) begin
        if (!RSTN) begin
            dac_reg <= sdwl_pkg::DAC_RESET; // zero code at power-up
        end else begin
            dac_reg <= shreg;
        end
    end

    // toggle event so the core domain learns of each load
    always_ff @(posedge LINK.frame_n or negedge RSTN) begin
        if (!RSTN) begin
            load_tgl <= 1'b0;
        end else begin
            load_tgl <= ~load_tgl;
        end
    end

    // two-flop synchroniser plus edge history
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tgl_sync <= '0;
        end else begin
            tgl_sync <= {tgl_sync[1:0], load_tgl};
        end
    end

    // dac_reg is stable long before the toggle is seen, so it is sampled safely
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DAC_CODE <= sdwl_pkg::DAC_RESET;
            SEGMENT_SWITCH_CTL <= '0;
            LADDER_SWITCH_CTL <= '0;
            LOAD_DONE <= 1'b0;
        end else begin
            LOAD_DONE <= tgl_sync[2] ^ tgl_sync[1];
            if (tgl_sync[2] ^ tgl_sync[1]) begin
                DAC_CODE <= dac_reg; // unsigned code, vref*d/16384
                SEGMENT_SWITCH_CTL <= therm(dac_reg[WORD_BITS-1 -: sdwl_pkg::SEG_BITS]);
                LADDER_SWITCH_CTL <= dac_reg[sdwl_pkg::LADDER_BITS-1:0];
            end
        end
    end
endmodule

// ---- bench/sdwl_link_properties.sv ----
// framing and timing checks on the serial wire between the two ends
`timescale 1ns/1ps
module sdwl_link_properties (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic sclk,
    input wire logic frame_n,
    input wire logic sdata
);
    logic [4:0] n_rise;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    // rising sclk edges in the open frame, cleared while idle
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)
            n_rise <= 5'h00;
        else if (frame_n)
            n_rise <= 5'h00;
        else if ($rose(sclk))
            n_rise <= n_rise + 5'h01;
    end
    AST_IDLE_LOW: assert property (frame_n |-> !sclk)
        else $error("sclk high outside a frame");
    AST_RISE_IN_FRAME: assert property ($rose(sclk) |-> !frame_n)
        else $error("sclk rose with frame high");
    AST_HIGH_HALF: assert property ($rose(sclk) |=> $fell(sclk))
        else $error("sclk high phase wrong length");
    AST_LOW_HALF: assert property ($fell(sclk) && !frame_n |=> $rose(sclk) || $rose(frame_n))
        else $error("sclk low phase wrong length");
    AST_DATA_SETUP: assert property ($rose(sclk) |-> $stable(sdata))
        else $error("sdata moved at the sampling edge");
    AST_END_SCLK_LOW: assert property ($rose(frame_n) |-> !sclk && !$past(sclk))
        else $error("frame closed with sclk high");
    AST_FOURTEEN: assert property ($rose(frame_n) |-> n_rise == 5'h0E)
        else $error("frame did not carry fourteen bits");
    AST_NO_EXTRA: assert property (!frame_n |-> n_rise <= 5'h0E)
        else $error("more than fourteen bits in a host frame");
    AST_FRAME_LEN: assert property ($fell(frame_n) |-> ##[20:40] $rose(frame_n))
        else $error("frame did not close in time");
    cover property ($fell(frame_n));
    cover property ($rose(frame_n) && n_rise == 5'h0E);
    cover property ($rose(sclk) && sdata);
endmodule

// ---- bench/serial_dac_word_loader_tb_top.sv ----
// bench: host end feeds dac end; a second dac is driven by hand
`timescale 1ns/1ps
module serial_dac_word_loader_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b1;
    logic word_valid = 1'b0;
    logic [13:0] word_data = 14'h0000;
    logic word_ready, busy, done_a, done_b;
    logic [14:0] seg_a, seg_b;
    logic [9:0] lad_a, lad_b;
    logic [13:0] code_a, code_b;
    logic [13:0] exp_q[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int n_load_a = 0;
    int n_load_b = 0;
    int n_refused = 0;
    int k;
    sdwl_link_if link();
    sdwl_link_if link_b();
    sdwl_host u_sdwl_host (.CLK(clk), .RSTN(rstn), .WORD_VALID(word_valid),
        .WORD_READY(word_ready), .WORD_DATA(word_data), .BUSY(busy), .LINK(link));
    sdwl_dac u_sdwl_dac (.CLK(clk), .RSTN(rstn), .LINK(link), .SEGMENT_SWITCH_CTL(seg_a),
        .LADDER_SWITCH_CTL(lad_a), .DAC_CODE(code_a), .LOAD_DONE(done_a));
    sdwl_dac u_sdwl_dac_b (.CLK(clk), .RSTN(rstn), .LINK(link_b), .SEGMENT_SWITCH_CTL(seg_b),
        .LADDER_SWITCH_CTL(lad_b), .DAC_CODE(code_b), .LOAD_DONE(done_b));
    sdwl_link_properties u_sdwl_link_properties (.CLK(clk), .RSTN(rstn), .sclk(link.sclk),
        .frame_n(link.frame_n), .sdata(link.sdata));
    // 40 MHz system clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [14:0] therm(input logic [3:0] n);
        return 15'((16'h0001 << n) - 16'h0001);
    endfunction
    task check(input logic [15:0] seen, input logic [15:0] expd);
        n_compared++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, expd);
        end
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // valid held until ready is seen high at an edge
    task put(input logic [13:0] w);
        int t;
        t = 0;
        @(posedge clk);
        word_valid <= 1'b1;
        word_data <= w;
        do begin
            @(posedge clk);
            t++;
        end while (word_ready !== 1'b1 && t < 2000);
        if (word_ready !== 1'b1)
            n_mismatch++;
        word_valid <= 1'b0;
        exp_q.push_back(w);
    endtask
    // hand-made frame; fr high sends clocks with the frame closed
    task send_b(input logic [15:0] w, input int n, input logic fr);
        int i;
        @(posedge clk);
        link_b.frame_n <= fr;
        for (i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            link_b.sdata <= w[i];
            @(posedge clk);
            link_b.sclk <= 1'b1;
            @(posedge clk);
            link_b.sclk <= 1'b0;
        end
        @(posedge clk);
        link_b.frame_n <= 1'b1;
        link_b.sdata <= ~link_b.sdata; // released line must not keep its value
        repeat (8) @(posedge clk);
    endtask
    // outputs looked at mid-cycle, away from the launching edge
    always @(negedge clk) begin
        if (done_a === 1'b1 && exp_q.size() > 0) begin
            check(16'(code_a), 16'(exp_q[0]));
            check(16'(seg_a), 16'(therm(exp_q[0][13:10])));
            check(16'(lad_a), 16'(exp_q[0][9:0]));
            void'(exp_q.pop_front());
        end
        if (done_a === 1'b1)
            n_load_a++;
        if (done_b === 1'b1)
            n_load_b++;
        if (word_valid && word_ready === 1'b0)
            n_refused++;
    end
    initial begin
        // reset edge after every process waits, so both ends clear at time zero
        rstn <= 1'b0;
        link_b.sclk <= 1'b0;
        link_b.frame_n <= 1'b1;
        link_b.sdata <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        check(16'(code_a), 16'h0000);
        check(16'(seg_a), 16'h0000);
        // sixteen words, every segment count, pushed faster than the link drains
        for (k = 0; k < 16; k++)
            put({4'(k), 10'(k * 73 + 1)});
        k = 0;
        while (exp_q.size() > 0 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        if (exp_q.size() > 0)
            n_mismatch++;
        repeat (8) @(posedge clk);
        check(16'(busy), 16'h0000);
        check(16'(n_refused > 0), 16'h0001);
        check(16'(n_load_a), 16'h0010);
        send_b(16'hA5C3, 16, 1'b0);
        check(16'(code_b), 16'h25C3);
        check(16'(seg_b), 16'h01FF);
        check(16'(lad_b), 16'h01C3);
        send_b(16'h5A5A, 5, 1'b1);
        check(16'(code_b), 16'h25C3);
        send_b(16'h0009, 4, 1'b0);
        check(16'(code_b), 16'h1C39);
        check(16'(seg_b), 16'h007F);
        check(16'(lad_b), 16'h0039);
        check(16'(n_load_b), 16'h0002);
        finish_test();
    end
    // watchdog well beyond the expected run of about 15 us
    initial begin
        #300000;
        n_mismatch++;
        finish_test();
    end
endmodule
